// ### hw/ied_datapath.sv
`timescale 1ns/1ps
`include "ied_defs.svh"
module ied_datapath #(
	parameter int DAW = 10, // Data memory address width, above 8.
	parameter int PAW = 13 // Program memory address width, 9 to 16.
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [PAW-1:0] prog_addr_o,
	input wire logic [15:0] prog_data_i,
	output logic busy_o
);

	ied_pkg::ied_state_t state_q; // Sequencer state.
	ied_pkg::ied_state_t state_d; // Next sequencer state.
	ied_pkg::ied_op_t op_q; // Operation in progress.
	logic [DAW-1:0] addr_q; // Operand address.
	logic [2:0] bit_q; // Selected bit index.
	logic long_q; // Operand address is a full address.
	logic [7:0] imm_q; // Immediate operand.
	logic [7:0] acc_q; // Accumulator.
	logic [7:0] table_pointer_low_q; // Table pointer low byte.
	logic [7:0] table_pointer_high_q; // Table pointer high byte.
	logic [7:0] table_high_byte_holder_q; // Table high byte holder.
	logic [7:0] last_q; // Last result produced.
	logic [DAW-9:0] bank_q; // Bank for short addresses.
	logic [DAW-1:0] maddr_q; // Host memory window address.
	logic [4:0] flags_q; // Status flags.
	logic skip_q; // Last operation skipped.
	logic [7:0] res; // Result of the executing operation.
	logic wr_mem; // Result goes to data memory.
	logic wr_acc; // Result goes to accumulator.
	logic upd_z; // Only the zero flag follows the result.
	logic upd_ar; // Arithmetic flags follow the adder.
	logic upd_c; // Carry follows the decimal adjust.
	logic skip; // Next instruction is skipped.

	// Bus request decode; one request is taken per bus cycle.
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire idle = state_q == ied_pkg::ST_IDLE;
	wire exec = state_q == ied_pkg::ST_EXEC;
	wire hwr = wr & idle;
	wire hit_cmd = wb_adr_i == `IED_REG_CMD;
	wire hit_opadr = wb_adr_i == `IED_REG_OPADR;
	wire hit_imm = wb_adr_i == `IED_REG_IMM;
	wire hit_acc = wb_adr_i == `IED_REG_ACC;
	wire hit_flags = wb_adr_i == `IED_REG_FLAGS;
	wire hit_status = wb_adr_i == `IED_REG_STATUS;
	wire hit_table_pointer_low = wb_adr_i == `IED_REG_TABLE_POINTER_LOW;
	wire hit_table_pointer_high = wb_adr_i == `IED_REG_TABLE_POINTER_HIGH;
	wire hit_table_high_byte_holder = wb_adr_i == `IED_REG_TABLE_HIGH_BYTE_HOLDER;
	wire hit_bank = wb_adr_i == `IED_REG_BANK;
	wire hit_maddr = wb_adr_i == `IED_REG_MADDR;
	wire hit_mdata = wb_adr_i == `IED_REG_MDATA;
	wire go = hwr & hit_cmd;
	wire [4:0] go_op = wb_dat_i[`IED_CMD_OP_MSB:0];

	// Operation classes.
	wire preinc = go & ((go_op == ied_pkg::OP_TRDI) |
		(go_op == ied_pkg::OP_TRDLI));
	wire tbl_op = (op_q == ied_pkg::OP_TRD) | (op_q == ied_pkg::OP_TRDL) |
		(op_q == ied_pkg::OP_TRDI) | (op_q == ied_pkg::OP_TRDLI);
	wire final_pg = (op_q == ied_pkg::OP_TRDL) |
		(op_q == ied_pkg::OP_TRDLI);
	wire with_c = (op_q == ied_pkg::OP_ADC) | (op_q == ied_pkg::OP_ADCM);

	// Program addresses; the final page ignores the high pointer.
	wire [15:0] page_addr = {table_pointer_high_q, table_pointer_low_q};
	wire [15:0] last_addr = {`IED_FINAL_PAGE, table_pointer_low_q};
	wire [PAW-1:0] prog_d = final_pg ? last_addr[PAW-1:0] :
		page_addr[PAW-1:0];

	// Long forms use the full address, short forms the bank.
	wire [DAW-1:0] eff_addr = long_q ? addr_q :
		{bank_q, addr_q[7:0]};
	wire [DAW-1:0] mem_addr = idle ? maddr_q : eff_addr;
	wire mem_we = (exec & wr_mem) | (hwr & hit_mdata);
	wire [7:0] mem_wdata = exec ? res : wb_dat_i[7:0];
	wire [7:0] mem_rdata;

	// Adder with nibble carry for the arithmetic flags.
	wire cin = with_c & flags_q[`IED_FLG_C];
	wire [8:0] sum9 = {1'b0, acc_q} + {1'b0, mem_rdata} + {8'h00, cin};
	wire [4:0] sum5 = {1'b0, acc_q[3:0]} + {1'b0, mem_rdata[3:0]} +
		{4'h0, cin};
	wire ovf = (acc_q[7] == mem_rdata[7]) & (sum9[7] != acc_q[7]);

	// Decimal adjust by nibble, judged on the original nibbles.
	wire lo_adj = (acc_q[3:0] > `IED_BCD_MAX) | flags_q[`IED_FLG_AC];
	wire hi_adj = (acc_q[7:4] > `IED_BCD_MAX) | flags_q[`IED_FLG_C];
	wire [7:0] adj = {hi_adj ? `IED_BCD_ADJ : 4'h0,
		lo_adj ? `IED_BCD_ADJ : 4'h0};
	wire [8:0] daa9 = {1'b0, acc_q} + {1'b0, adj};
	wire [7:0] bsel = 8'h01 << bit_q;
	wire [7:0] swap_w = {mem_rdata[3:0], mem_rdata[7:4]};
	wire [4:0] flags_w = flags_q;

	// Read data selection for the bus.
	wire [31:0] rd_mux =
		hit_cmd ? {23'h0, long_q, bit_q, op_q} :
		hit_opadr ? {{(32-DAW){1'b0}}, addr_q} :
		hit_imm ? {24'h0, imm_q} :
		hit_acc ? {24'h0, acc_q} :
		hit_flags ? {27'h0, flags_q} :
		hit_status ? {16'h0, last_q, 6'h0, skip_q, ~idle} :
		hit_table_pointer_low ? {24'h0, table_pointer_low_q} :
		hit_table_pointer_high ? {24'h0, table_pointer_high_q} :
		hit_table_high_byte_holder ? {24'h0, table_high_byte_holder_q} :
		hit_bank ? {{(40-DAW){1'b0}}, bank_q} :
		hit_maddr ? {{(32-DAW){1'b0}}, maddr_q} :
		hit_mdata ? {24'h0, mem_rdata} : 32'h0;

	// Data memory.
	ied_dmem #(
		.AW(DAW),
		.DW(8)
	) u_dmem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(mem_wdata),
		.rdata_o(mem_rdata)
	);

	// Result, destination and flag selection during execution.
	always_comb
	begin
		res = mem_rdata;
		wr_mem = 1'b0;
		wr_acc = 1'b0;
		upd_z = 1'b0;
		upd_ar = 1'b0;
		upd_c = 1'b0;
		skip = 1'b0;
		case (op_q)
			ied_pkg::OP_SWAP:
			begin
				res = swap_w;
				wr_mem = 1'b1;
			end
			ied_pkg::OP_NIBBLE_EXCHANGE_TO_ACC:
			begin
				res = swap_w;
				wr_acc = 1'b1;
			end
			ied_pkg::OP_SZ:
			begin
				wr_mem = 1'b1;
				skip = mem_rdata == 8'h00;
			end
			ied_pkg::OP_SZA:
			begin
				wr_acc = 1'b1;
				skip = mem_rdata == 8'h00;
			end
			ied_pkg::OP_SZBIT:
				skip = ~mem_rdata[bit_q];
			ied_pkg::OP_TRD, ied_pkg::OP_TRDL,
			ied_pkg::OP_TRDI, ied_pkg::OP_TRDLI:
			begin
				res = prog_data_i[7:0];
				wr_mem = 1'b1;
			end
			ied_pkg::OP_XORA, ied_pkg::OP_EXCLUSIVE_OR_TO_MEM:
			begin
				res = acc_q ^ mem_rdata;
				wr_acc = op_q == ied_pkg::OP_XORA;
				wr_mem = op_q == ied_pkg::OP_EXCLUSIVE_OR_TO_MEM;
				upd_z = 1'b1;
			end
			ied_pkg::OP_XORI:
			begin
				res = acc_q ^ imm_q;
				wr_acc = 1'b1;
				upd_z = 1'b1;
			end
			ied_pkg::OP_ADD, ied_pkg::OP_ADC,
			ied_pkg::OP_ADDM, ied_pkg::OP_ADCM:
			begin
				res = sum9[7:0];
				wr_acc = (op_q == ied_pkg::OP_ADD) |
					(op_q == ied_pkg::OP_ADC);
				wr_mem = ~wr_acc;
				upd_ar = 1'b1;
			end
			ied_pkg::OP_AND, ied_pkg::OP_ANDM:
			begin
				res = acc_q & mem_rdata;
				wr_acc = op_q == ied_pkg::OP_AND;
				wr_mem = op_q == ied_pkg::OP_ANDM;
				upd_z = 1'b1;
			end
			ied_pkg::OP_CLR:
			begin
				res = `IED_RST_BYTE;
				wr_mem = 1'b1;
			end
			ied_pkg::OP_CLRBIT:
			begin
				res = mem_rdata & ~bsel;
				wr_mem = 1'b1;
			end
			ied_pkg::OP_CPL, ied_pkg::OP_CPLA:
			begin
				res = ~mem_rdata;
				wr_acc = op_q == ied_pkg::OP_CPLA;
				wr_mem = op_q == ied_pkg::OP_CPL;
				upd_z = 1'b1;
			end
			ied_pkg::OP_DAA:
			begin
				res = daa9[7:0];
				wr_mem = 1'b1;
				upd_c = 1'b1;
			end
			ied_pkg::OP_DEC, ied_pkg::OP_DECA:
			begin
				res = mem_rdata - 8'h01;
				wr_acc = op_q == ied_pkg::OP_DECA;
				wr_mem = op_q == ied_pkg::OP_DEC;
				upd_z = 1'b1;
			end
			ied_pkg::OP_INC, ied_pkg::OP_INCA:
			begin
				res = mem_rdata + 8'h01;
				wr_acc = op_q == ied_pkg::OP_INCA;
				wr_mem = op_q == ied_pkg::OP_INC;
				upd_z = 1'b1;
			end
			default:
				res = mem_rdata;
		endcase
	end

	// Sequencer: table reads wait one cycle for program memory.
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ied_pkg::ST_IDLE:
				if (go)
					state_d = ied_pkg::ST_READ;
			ied_pkg::ST_READ:
				state_d = tbl_op ? ied_pkg::ST_FETCH : ied_pkg::ST_EXEC;
			ied_pkg::ST_FETCH:
				state_d = ied_pkg::ST_EXEC;
			ied_pkg::ST_EXEC:
				state_d = skip ? ied_pkg::ST_SKIP : ied_pkg::ST_IDLE;
			ied_pkg::ST_SKIP:
				state_d = ied_pkg::ST_IDLE;
			default:
				state_d = ied_pkg::ST_IDLE;
		endcase
	end

	// State register and busy output.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ied_pkg::ST_IDLE;
			busy_o <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			busy_o <= state_d != ied_pkg::ST_IDLE;
		end
	end

	// Command capture; writes are taken only while idle.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			op_q <= ied_pkg::OP_SWAP;
			bit_q <= 3'h0;
			long_q <= 1'b0;
			addr_q <= '0;
			imm_q <= `IED_RST_BYTE;
		end
		else if (go)
		begin
			op_q <= ied_pkg::ied_op_t'(go_op);
			bit_q <= wb_dat_i[`IED_CMD_BIT_MSB:`IED_CMD_BIT_LSB];
			long_q <= wb_dat_i[`IED_CMD_LONG];
		end
		else if (hwr & hit_opadr)
			addr_q <= wb_dat_i[DAW-1:0];
		else if (hwr & hit_imm)
			imm_q <= wb_dat_i[7:0];
	end

	// Accumulator: execution result or host write.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			acc_q <= `IED_RST_BYTE;
		else if (exec & wr_acc)
			acc_q <= res;
		else if (hwr & hit_acc)
			acc_q <= wb_dat_i[7:0];
	end

	// Flags: only the flags named by the operation change.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			flags_q <= 5'h00;
		else if (exec & upd_ar)
		begin
			flags_q[`IED_FLG_C] <= sum9[8];
			flags_q[`IED_FLG_AC] <= sum5[4];
			flags_q[`IED_FLG_OV] <= ovf;
			flags_q[`IED_FLG_SC] <= ovf ^ sum9[7];
			flags_q[`IED_FLG_Z] <= sum9[7:0] == 8'h00;
		end
		else if (exec & upd_z)
			flags_q[`IED_FLG_Z] <= res == 8'h00;
		else if (exec & upd_c)
			flags_q[`IED_FLG_C] <= flags_q[`IED_FLG_C] | daa9[8];
		else if (hwr & hit_flags)
			flags_q <= wb_dat_i[4:0];
	end

	// Table pointers, holder and program address.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			table_pointer_low_q <= `IED_RST_BYTE;
			table_pointer_high_q <= `IED_RST_BYTE;
			table_high_byte_holder_q <= `IED_RST_BYTE;
			prog_addr_o <= '0;
		end
		else
		begin
			if (preinc)
				table_pointer_low_q <= table_pointer_low_q + 8'h01;
			else if (hwr & hit_table_pointer_low)
				table_pointer_low_q <= wb_dat_i[7:0];
			if (hwr & hit_table_pointer_high)
				table_pointer_high_q <= wb_dat_i[7:0];
			if (exec & tbl_op)
				table_high_byte_holder_q <= prog_data_i[15:8];
			if (state_q == ied_pkg::ST_READ)
				prog_addr_o <= prog_d;
		end
	end

	// Bank, memory window, skip and last result.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bank_q <= '0;
			maddr_q <= '0;
			skip_q <= 1'b0;
			last_q <= `IED_RST_BYTE;
		end
		else
		begin
			if (hwr & hit_bank)
				bank_q <= wb_dat_i[DAW-9:0];
			if (hwr & hit_maddr)
				maddr_q <= wb_dat_i[DAW-1:0];
			if (go)
				skip_q <= 1'b0;
			else if (exec)
			begin
				skip_q <= skip;
				last_q <= res;
			end
		end
	end

	// Wishbone answer one cycle after the request, then dropped.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= rd_mux;
		end
	end

	sequence s_sz_zero;
		exec && op_q == ied_pkg::OP_SZ && mem_rdata == 8'h00;
	endsequence
	sequence s_skip_end;
		state_q == ied_pkg::ST_SKIP ##1 state_q == ied_pkg::ST_IDLE;
	endsequence

	property p_swap;
		@(posedge clk_i) disable iff (rst_i)
		exec && op_q == ied_pkg::OP_SWAP |-> mem_we &&
		mem_wdata == swap_w ##1 flags_w == $past(flags_w);
	endproperty
	a_swap: assert property (p_swap) else $error("swap bad");
	property p_nibble_exchange_to_acc;
		@(posedge clk_i) disable iff (rst_i)
		exec && op_q == ied_pkg::OP_NIBBLE_EXCHANGE_TO_ACC |-> !mem_we
		##1 acc_q == $past(swap_w);
	endproperty
	a_nibble_exchange_to_acc: assert property (p_nibble_exchange_to_acc) else $error("nibble_exchange_to_acc bad");
	property p_sz;
		@(posedge clk_i) disable iff (rst_i)
		s_sz_zero |-> mem_we ##1 s_skip_end;
	endproperty
	a_sz: assert property (p_sz) else $error("zero skip bad");
	property p_sza;
		@(posedge clk_i) disable iff (rst_i)
		exec && op_q == ied_pkg::OP_SZA && mem_rdata == 8'h00
		|=> acc_q == 8'h00 ##0 s_skip_end;
	endproperty
	a_sza: assert property (p_sza) else $error("sza bad");
	property p_szbit;
		@(posedge clk_i) disable iff (rst_i)
		exec && op_q == ied_pkg::OP_SZBIT && mem_rdata[bit_q]
		|=> state_q == ied_pkg::ST_IDLE && !skip_q;
	endproperty
	a_szbit: assert property (p_szbit) else $error("bit skip");
	property p_trd;
		@(posedge clk_i) disable iff (rst_i)
		state_q == ied_pkg::ST_FETCH && op_q == ied_pkg::OP_TRD
		|-> prog_addr_o == page_addr[PAW-1:0] ##1 mem_we &&
		mem_wdata == prog_data_i[7:0] ##1
		table_high_byte_holder_q == $past(prog_data_i[15:8]);
	endproperty
	a_trd: assert property (p_trd) else $error("table read");
	property p_trdli;
		@(posedge clk_i) disable iff (rst_i)
		go && go_op == ied_pkg::OP_TRDLI |=> table_pointer_low_q == $past(table_pointer_low_q)
		+ 8'h01 ##1 prog_addr_o == last_addr[PAW-1:0];
	endproperty
	a_trdli: assert property (p_trdli) else $error("final inc");
	property p_xori;
		@(posedge clk_i) disable iff (rst_i)
		exec && op_q == ied_pkg::OP_XORI |=> acc_q == $past(res) &&
		flags_q[`IED_FLG_C] == $past(flags_q[`IED_FLG_C]);
	endproperty
	a_xori: assert property (p_xori) else $error("xor bad");
	property p_long;
		@(posedge clk_i) disable iff (rst_i)
		exec && long_q |-> mem_addr == addr_q;
	endproperty
	a_long: assert property (p_long) else $error("long addr");
	property p_adc;
		@(posedge clk_i) disable iff (rst_i)
		exec && op_q == ied_pkg::OP_ADC |=>
		{flags_q[`IED_FLG_C], acc_q} == $past(sum9);
	endproperty
	a_adc: assert property (p_adc) else $error("add carry");
	property p_daa;
		@(posedge clk_i) disable iff (rst_i)
		exec && op_q == ied_pkg::OP_DAA |-> mem_we ##1
		flags_q[4:1] == $past(flags_q[4:1]);
	endproperty
	a_daa: assert property (p_daa) else $error("daa flags");
	property p_zero;
		@(posedge clk_i) disable iff (rst_i)
		exec && upd_z |=> flags_q[`IED_FLG_Z] == ($past(res) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag");

endmodule : ied_datapath

// ### hw/ied_defs.svh
`ifndef IED_DEFS_SVH
`define IED_DEFS_SVH

// Register byte offsets on the Wishbone bus.
`define IED_REG_CMD 8'h00
`define IED_REG_OPADR 8'h04
`define IED_REG_IMM 8'h08
`define IED_REG_ACC 8'h0C
`define IED_REG_FLAGS 8'h10
`define IED_REG_STATUS 8'h14
`define IED_REG_TABLE_POINTER_LOW 8'h18
`define IED_REG_TABLE_POINTER_HIGH 8'h1C
`define IED_REG_TABLE_HIGH_BYTE_HOLDER 8'h20
`define IED_REG_BANK 8'h24
`define IED_REG_MADDR 8'h28
`define IED_REG_MDATA 8'h2C

// Command register fields.
`define IED_CMD_OP_MSB 4
`define IED_CMD_BIT_LSB 5
`define IED_CMD_BIT_MSB 7
`define IED_CMD_LONG 8

// Flag register bit positions.
`define IED_FLG_C 0
`define IED_FLG_AC 1
`define IED_FLG_Z 2
`define IED_FLG_OV 3
`define IED_FLG_SC 4

// Status register bit positions.
`define IED_STS_BUSY 0
`define IED_STS_SKIP 1
`define IED_STS_RES_LSB 8

// Decimal adjust constants, reset values and the final table page.
`define IED_BCD_MAX 4'h9
`define IED_BCD_ADJ 4'h6
`define IED_RST_BYTE 8'h00
`define IED_FINAL_PAGE 8'hFF

`endif

// ### hw/ied_pkg.sv
package ied_pkg;

	// Operation codes written into the command register.
	typedef enum logic [4:0] {
		OP_SWAP = 5'h00, OP_NIBBLE_EXCHANGE_TO_ACC = 5'h01, OP_SZ = 5'h02,
		OP_SZA = 5'h03, OP_SZBIT = 5'h04, OP_TRD = 5'h05,
		OP_TRDL = 5'h06, OP_TRDI = 5'h07, OP_TRDLI = 5'h08,
		OP_XORA = 5'h09, OP_EXCLUSIVE_OR_TO_MEM = 5'h0A, OP_XORI = 5'h0B,
		OP_ADD = 5'h0C, OP_ADDM = 5'h0D, OP_ADC = 5'h0E,
		OP_ADCM = 5'h0F, OP_AND = 5'h10, OP_ANDM = 5'h11,
		OP_CLR = 5'h12, OP_CLRBIT = 5'h13, OP_CPL = 5'h14,
		OP_CPLA = 5'h15, OP_DAA = 5'h16, OP_DEC = 5'h17,
		OP_DECA = 5'h18, OP_INC = 5'h19, OP_INCA = 5'h1A
	} ied_op_t;

	// Sequencer states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001, ST_READ = 5'b00010, ST_EXEC = 5'b00100,
		ST_FETCH = 5'b01000, ST_SKIP = 5'b10000
	} ied_state_t;

endpackage : ied_pkg

// ### hw/ied_dmem.sv
`timescale 1ns/1ps

// Single port data memory with a registered read port.
module ied_dmem #(
	parameter int AW = 10, // Address width.
	parameter int DW = 8 // Data width.
)(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);

	// Storage array, left uninitialised like real RAM.
	logic [DW-1:0] mem_q [0:(1<<AW)-1];

	// Write port; a read in the same cycle returns the old byte.
	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem_q[addr_i] <= wdata_i;
	end

	// Read data register, cleared by reset.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_o <= '0;
		else
			rdata_o <= mem_q[addr_i];
	end

endmodule : ied_dmem

// ### tb/test_mcu_instr_exec_datapath.sv
`timescale 1ns/1ps
`include "ied_defs.svh"

// Self-checking bench: the bus driver notes each expected result in a queue.
module test_mcu_instr_exec_datapath;
	// One expected read result with the bits that count.
	typedef struct {
		logic [31:0] v;
		logic [31:0] m;
	} ied_exp_t;
	// One directed case: op, bit, memory byte, accumulator, flags.
	typedef struct {
		logic [4:0] o;
		logic [2:0] b;
		logic [7:0] mv;
		logic [7:0] av;
		logic [4:0] f;
	} ied_case_t;
	logic clk_i = 1'b0; // Core clock, 100 ns period.
	logic rst_i = 1'b1; // Synchronous reset, held at start.
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [12:0] prog_addr_o;
	logic [15:0] prog_data_i = 16'h0000;
	logic busy_o;
	ied_exp_t rdq[$]; // Reads still waiting for their answer.
	int cycq[$]; // Busy lengths still waiting for their operation.
	int errors = 0;
	int n_compared = 0;
	int bcnt = 0; // Busy cycles seen in the running operation.
	logic [7:0] mem_m [0:1023]; // Model of the data memory.
	logic [7:0] accum_m;
	logic [7:0] imm_m;
	logic [7:0] tlo_m;
	logic [7:0] thi_m;
	logic [7:0] thold_m;
	logic [4:0] fl_m;
	logic [1:0] bank_m;
	localparam logic [7:0] RA [0:7] = '{`IED_REG_STATUS, `IED_REG_FLAGS,
		`IED_REG_ACC, `IED_REG_TABLE_POINTER_LOW, `IED_REG_TABLE_POINTER_HIGH, `IED_REG_TABLE_HIGH_BYTE_HOLDER,
		`IED_REG_BANK, 8'h30};
	ied_case_t tc [0:27] = '{
		'{ied_pkg::OP_SWAP, 3'h0, 8'hA5, 8'h00, 5'h1F},
		'{ied_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h3C, 8'h00, 5'h1F},
		'{ied_pkg::OP_SZ, 3'h0, 8'h00, 8'h11, 5'h00},
		'{ied_pkg::OP_SZ, 3'h0, 8'h01, 8'h11, 5'h00},
		'{ied_pkg::OP_SZA, 3'h0, 8'h00, 8'h55, 5'h1F},
		'{ied_pkg::OP_SZA, 3'h0, 8'h80, 8'h55, 5'h00},
		'{ied_pkg::OP_SZBIT, 3'h7, 8'h7F, 8'h00, 5'h1F},
		'{ied_pkg::OP_SZBIT, 3'h0, 8'h01, 8'h00, 5'h00},
		'{ied_pkg::OP_XORA, 3'h0, 8'h5A, 8'h5A, 5'h1B},
		'{ied_pkg::OP_EXCLUSIVE_OR_TO_MEM, 3'h0, 8'hF0, 8'h0F, 5'h04},
		'{ied_pkg::OP_XORI, 3'h0, 8'hC3, 8'hC3, 5'h1B},
		'{ied_pkg::OP_ADD, 3'h0, 8'h01, 8'h7F, 5'h00},
		'{ied_pkg::OP_ADDM, 3'h0, 8'h01, 8'hFF, 5'h00},
		'{ied_pkg::OP_ADC, 3'h0, 8'h00, 8'h0F, 5'h01},
		'{ied_pkg::OP_ADCM, 3'h0, 8'h80, 8'h80, 5'h01},
		'{ied_pkg::OP_AND, 3'h0, 8'hF0, 8'h0F, 5'h00},
		'{ied_pkg::OP_ANDM, 3'h0, 8'hF5, 8'h3C, 5'h04},
		'{ied_pkg::OP_CLR, 3'h0, 8'h5A, 8'h00, 5'h1B},
		'{ied_pkg::OP_CLRBIT, 3'h3, 8'hFF, 8'h00, 5'h04},
		'{ied_pkg::OP_CPL, 3'h0, 8'hFF, 8'h00, 5'h00},
		'{ied_pkg::OP_CPLA, 3'h0, 8'h0F, 8'h00, 5'h04},
		'{ied_pkg::OP_DAA, 3'h0, 8'h00, 8'h1F, 5'h1C},
		'{ied_pkg::OP_DAA, 3'h0, 8'h00, 8'hA0, 5'h00},
		'{ied_pkg::OP_DAA, 3'h0, 8'h00, 8'h99, 5'h03},
		'{ied_pkg::OP_DEC, 3'h0, 8'h00, 8'h00, 5'h04},
		'{ied_pkg::OP_DECA, 3'h0, 8'h01, 8'h00, 5'h00},
		'{ied_pkg::OP_INC, 3'h0, 8'hFF, 8'h00, 5'h00},
		'{ied_pkg::OP_INCA, 3'h0, 8'h7F, 8'h00, 5'h04}
	};

	ied_datapath #(.DAW(10), .PAW(13)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prog_addr_o(prog_addr_o),
		.prog_data_i(prog_data_i), .busy_o(busy_o));

	// Free running clock.
	always #50 clk_i = ~clk_i;

	// Program word pattern, distinct as a whole word for every address.
	function automatic logic [15:0] rom(input logic [12:0] a);
		return {a[12:5] ^ 8'hA5, a[7:0] ^ 8'h3C};
	endfunction : rom

	// Synchronous program store: the word follows its address by one cycle.
	always @(posedge clk_i) prog_data_i <= rom(prog_addr_o);

	// Prints the counts and the verdict, then ends the run.
	task automatic results;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	// Counts and reports one mismatch.
	task automatic miss(input string s);
		errors++;
		$display("CHECK FAILED at %0t: %s", $time, s);
	endtask : miss

	// Compares read data under its mask.
	task automatic cmp_data(input ied_exp_t e, input logic [31:0] g);
		n_compared++;
		if ((g & e.m) !== e.v)
			miss($sformatf("read %h, expected %h", g, e.v));
	endtask : cmp_data

	// Compares the length of one busy period.
	task automatic cmp_cyc(input int e, input int g);
		n_compared++;
		if (g != e)
			miss($sformatf("busy %0d cycles, expected %0d", g, e));
	endtask : cmp_cyc

	// Watches answers and busy periods, taking the oldest note for each.
	always @(posedge clk_i)
	begin
		if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0)
		begin
			if (rdq.size() > 0)
				cmp_data(rdq.pop_front(), wb_dat_o);
			else
				miss("read answer without a note");
		end
		if (busy_o === 1'b1)
			bcnt++;
		else if (bcnt > 0)
		begin
			if (cycq.size() > 0)
				cmp_cyc(cycq.pop_front(), bcnt);
			else
				miss("busy period without a note");
			bcnt = 0;
		end
	end

	// One classic Wishbone cycle; entered just after a rising edge.
	task automatic wbx(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			miss("bus answer timeout");
			results();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wbx

	// Full word write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbx(1'b1, a, d, 4'hF);
	endtask : wr

	// Read that notes its expected value first.
	task automatic rd(input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] m);
		rdq.push_back('{v, m});
		wbx(1'b0, a, 32'h0, 4'hF);
	endtask : rd

	// Loads one data memory byte through the memory window.
	task automatic setm(input logic [9:0] a, input logic [7:0] v);
		wr(`IED_REG_MADDR, {22'h0, a});
		wr(`IED_REG_MDATA, {24'h0, v});
		mem_m[a] = v;
	endtask : setm

	// Loads accumulator, flags and immediate.
	task automatic prep(input logic [7:0] av, input logic [4:0] f,
		input logic [7:0] iv);
		wr(`IED_REG_ACC, {24'h0, av});
		wr(`IED_REG_FLAGS, {27'h0, f});
		wr(`IED_REG_IMM, {24'h0, iv});
		{accum_m, fl_m, imm_m} = {av, f, iv};
	endtask : prep

	// Predicts one operation, runs it, then checks accumulator, flags, status, holder, pointer low and the memory byte.
	task automatic op(input logic [4:0] o, input logic [2:0] b,
		input logic lg, input logic [9:0] a, input logic intr);
		logic [9:0] ea;
		logic [7:0] m;
		logic [7:0] r;
		logic [8:0] s;
		logic [15:0] w;
		logic [3:0] lo;
		logic [3:0] hi;
		logic ci;
		logic sk;
		logic da;
		logic dm;
		logic dz;
		int cy;
		int n;
		ea = lg ? a : {bank_m, a[7:0]};
		m = mem_m[ea];
		r = m;
		{sk, da, dm, dz} = 4'h0;
		cy = 2;
		ci = fl_m[`IED_FLG_C] & o[1];
		s = {1'b0, accum_m} + {1'b0, m} + {8'h00, ci};
		case (o)
			ied_pkg::OP_SWAP, ied_pkg::OP_NIBBLE_EXCHANGE_TO_ACC:
				{r, da, dm} = {m[3:0], m[7:4], o[0], ~o[0]};
			ied_pkg::OP_SZ: {sk, dm} = {m == 8'h00, 1'b1};
			ied_pkg::OP_SZA: {sk, da} = {m == 8'h00, 1'b1};
			ied_pkg::OP_SZBIT: sk = ~m[b];
			ied_pkg::OP_TRD, ied_pkg::OP_TRDL, ied_pkg::OP_TRDI,
			ied_pkg::OP_TRDLI:
			begin
				// Preincrement forms bump the pointer low byte before use.
				if (o == ied_pkg::OP_TRDI || o == ied_pkg::OP_TRDLI)
					tlo_m++;
				w = (o == ied_pkg::OP_TRD || o == ied_pkg::OP_TRDI) ?
					rom({thi_m[4:0], tlo_m}) : rom({5'h1F, tlo_m});
				{r, dm, thold_m, cy} = {w[7:0], 1'b1, w[15:8], 32'd3};
			end
			ied_pkg::OP_XORA, ied_pkg::OP_EXCLUSIVE_OR_TO_MEM:
				{r, da, dm, dz} = {accum_m ^ m, o[0], ~o[0], 1'b1};
			ied_pkg::OP_XORI: {r, da, dz} = {accum_m ^ imm_m, 2'b11};
			ied_pkg::OP_ADD, ied_pkg::OP_ADDM, ied_pkg::OP_ADC,
			ied_pkg::OP_ADCM:
			begin
				{r, da, dm, dz} = {s[7:0], ~o[0], o[0], 1'b1};
				fl_m[`IED_FLG_C] = s[8];
				fl_m[`IED_FLG_AC] = ({1'b0, accum_m[3:0]} + {1'b0, m[3:0]}
					+ {4'h0, ci}) > 5'h0F;
				fl_m[`IED_FLG_OV] = (accum_m[7] == m[7]) && (s[7] != m[7]);
				fl_m[`IED_FLG_SC] = fl_m[`IED_FLG_OV] ^ s[7];
			end
			ied_pkg::OP_AND, ied_pkg::OP_ANDM:
				{r, da, dm, dz} = {accum_m & m, ~o[0], o[0], 1'b1};
			ied_pkg::OP_CLR: {r, dm} = {8'h00, 1'b1};
			ied_pkg::OP_CLRBIT: {r[b], dm} = 2'b01;
			ied_pkg::OP_CPL, ied_pkg::OP_CPLA:
				{r, da, dm, dz} = {~m, o[0], ~o[0], 1'b1};
			ied_pkg::OP_DAA:
			begin
				// Both nibbles are judged on the unadjusted accumulator.
				lo = (accum_m[3:0] > 4'h9 || fl_m[`IED_FLG_AC]) ? 4'h6 : 4'h0;
				hi = (accum_m[7:4] > 4'h9 || fl_m[`IED_FLG_C]) ? 4'h6 : 4'h0;
				s = {1'b0, accum_m} + {1'b0, hi, lo};
				{r, dm} = {s[7:0], 1'b1};
				fl_m[`IED_FLG_C] = fl_m[`IED_FLG_C] | s[8];
			end
			ied_pkg::OP_DEC, ied_pkg::OP_DECA:
				{r, da, dm, dz} = {m - 8'h01, ~o[0], o[0], 1'b1};
			ied_pkg::OP_INC, ied_pkg::OP_INCA:
				{r, da, dm, dz} = {m + 8'h01, ~o[0], o[0], 1'b1};
			default: r = m;
		endcase
		cy = cy + sk;
		if (da)
			accum_m = r;
		if (dm)
			mem_m[ea] = r;
		if (dz)
			fl_m[`IED_FLG_Z] = (r == 8'h00);
		cycq.push_back(cy);
		wr(`IED_REG_OPADR, {22'h0, a});
		wr(`IED_REG_CMD, {23'h0, lg, b, o});
		// A write landing while busy must be ignored.
		if (intr)
			wr(`IED_REG_ACC, {24'h0, ~accum_m});
		n = 0;
		while (busy_o !== 1'b0 && n < 40)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 40)
		begin
			miss("operation did not finish");
			results();
		end
		rd(`IED_REG_ACC, {24'h0, accum_m}, 32'hFFFFFFFF);
		rd(`IED_REG_FLAGS, {27'h0, fl_m}, 32'hFFFFFFFF);
		rd(`IED_REG_STATUS, {16'h0, r, 6'h0, sk, 1'b0}, 32'h0000FF03);
		rd(`IED_REG_TABLE_HIGH_BYTE_HOLDER, {24'h0, thold_m}, 32'hFFFFFFFF);
		rd(`IED_REG_TABLE_POINTER_LOW, {24'h0, tlo_m}, 32'hFFFFFFFF);
		wr(`IED_REG_MADDR, {22'h0, ea});
		rd(`IED_REG_MDATA, {24'h0, mem_m[ea]}, 32'hFFFFFFFF);
	endtask : op

	// Main sequence.
	initial
	begin
		logic [9:0] ra;
		logic lgr;
		void'($urandom(2992));
		{accum_m, imm_m, tlo_m, thi_m, thold_m, fl_m, bank_m} = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values, read-only and unmapped places.
		foreach (RA[i])
			rd(RA[i], 32'h0, 32'hFFFFFFFF);
		wr(`IED_REG_TABLE_HIGH_BYTE_HOLDER, 32'h5A);
		wr(8'h30, 32'h5A);
		rd(`IED_REG_TABLE_HIGH_BYTE_HOLDER, 32'h0, 32'hFFFFFFFF);
		rd(8'h30, 32'h0, 32'hFFFFFFFF);
		$display("test reset done");
		foreach (tc[i])
		begin
			setm({2'b10, i[7:0]}, tc[i].mv);
			prep(tc[i].av, tc[i].f, tc[i].mv);
			op(tc[i].o, tc[i].b, 1'b1, {2'b10, i[7:0]}, 1'b0);
		end
		$display("test directed done");
		wr(`IED_REG_TABLE_POINTER_HIGH, 32'h12);
		wr(`IED_REG_TABLE_POINTER_LOW, 32'hFF);
		{thi_m, tlo_m} = 16'h12FF;
		for (int k = 8; k >= 5; k--)
		begin
			setm(10'h080 + k[9:0], 8'h00);
			op(k[4:0], 3'h0, 1'b1, 10'h080 + k[9:0], 1'b0);
		end
		$display("test table done");
		wr(`IED_REG_BANK, 32'h3);
		bank_m = 2'h3;
		setm(10'h3F0, 8'h41);
		setm(10'h0F0, 8'h20);
		op(ied_pkg::OP_INC, 3'h0, 1'b0, 10'h0F0, 1'b0);
		op(ied_pkg::OP_DEC, 3'h0, 1'b1, 10'h0F0, 1'b0);
		wr(`IED_REG_BANK, 32'h0);
		bank_m = 2'h0;
		$display("test addressing done");
		setm(10'h155, 8'h99);
		op(ied_pkg::OP_TRD, 3'h0, 1'b1, 10'h155, 1'b1);
		wbx(1'b1, `IED_REG_ACC, 32'h77, 4'hE);
		rd(`IED_REG_ACC, {24'h0, accum_m}, 32'hFFFFFFFF);
		$display("test refusal done");
		repeat (40)
		begin
			lgr = 1'($urandom_range(0, 1));
			ra = 10'($urandom_range(0, 1023));
			if (!lgr)
				ra[9:8] = 2'b00;
			tlo_m = 8'($urandom);
			thi_m = 8'($urandom);
			wr(`IED_REG_TABLE_POINTER_LOW, {24'h0, tlo_m});
			wr(`IED_REG_TABLE_POINTER_HIGH, {24'h0, thi_m});
			setm(ra, 8'($urandom));
			prep(8'($urandom), 5'($urandom), 8'($urandom));
			op(5'($urandom_range(0, 26)), 3'($urandom), lgr, ra, 1'b0);
		end
		$display("test random done");
		repeat (3) @(posedge clk_i);
		if (rdq.size() != 0 || cycq.size() != 0)
			miss("results still pending");
		results();
	end

endmodule : test_mcu_instr_exec_datapath
